// ==== memory_map_pkg.sv ====
/*
 memory map decoder package: region bases, sizes, register offsets, reset values.
 assumes a 32-bit byte-addressed core bus on a 20 MHz core clock.
*/
package memory_map_pkg;
   // top level regions
   localparam logic [31:0] FLASH_BASE = 32'h0008_0000;   // nonvolatile memory home
   localparam logic [31:0] SRAM_BASE = 32'h0001_0000;    // static ram home
   localparam logic [31:0] ALIAS_BASE = 32'h0000_0000;   // boot alias window
   localparam logic [31:0] PRS_BASE = 32'hFFFF_0000;     // peripheral_register_space
   localparam int FLASH_BANK_HW = 32768;                 // halfwords per bank
   localparam int FLASH_BANKS = 2;
   localparam int FLASH_BOOT_HW = 1024;                  // boot page halfwords, upper bank
   localparam int FLASH_PAGE_BYTES = 512;
   localparam int SRAM_WORDS = 2048;
   localparam logic [31:0] FLASH_BYTES = 32'h0002_0000;  // 128 kB
   localparam logic [31:0] SRAM_BYTES = 32'h0000_2000;   // 8 kB
   localparam logic [31:0] PRS_BYTES = 32'h0001_0000;    // top two 32 kB pages
   // peripheral group offsets within the register space
   localparam logic [15:0] IRQ_OFS = 16'h0000;
   localparam logic [15:0] FIQ_OFS = 16'h0100;
   localparam logic [15:0] SYS_OFS = 16'h0200;
   localparam logic [15:0] TMR_OFS = 16'h0300;
   localparam logic [15:0] TMR_STRIDE = 16'h0020;
   localparam int TMR_COUNT = 5;
   localparam logic [15:0] PWR_OFS = 16'h0400;
   localparam logic [15:0] PSM_OFS = 16'h0440;
   localparam logic [15:0] REF_OFS = 16'h0480;
   localparam logic [15:0] ADC_OFS = 16'h0500;
   localparam logic [15:0] DAC_OFS = 16'h0580;
   localparam logic [15:0] DAC_STRIDE = 16'h0008;
   localparam int DAC_COUNT = 12;
   localparam logic [15:0] GPIO_OFS = 16'h0D00;
   localparam logic [15:0] NVC_OFS = 16'h0E00;
   // system control registers
   localparam logic [15:0] BOOT_ALIAS_OFS = 16'h0220;
   localparam logic [15:0] RST_CAUSE_OFS = 16'h0230;
   localparam logic [15:0] RST_CLEAR_OFS = 16'h0234;
   localparam logic [7:0] BOOT_ALIAS_RST = 8'h01;        // bit0 set: flash at zero
   localparam int BOOT_ALIAS_BIT = 0;
   localparam logic [7:0] RST_CAUSE_RST = 8'h01;         // power-on cause
   // wait counts in core cycles
   localparam int FAST_CYCLES = 1;
   localparam int SLOW_CYCLES = 2;
   localparam int FLASH_HW_ACCESSES = 2;                 // per 32-bit fetch
   // flash speed limits in kHz and the core clock rate
   localparam int CLK_KHZ = 20000;
   localparam int FLASH16_KHZ = 41780;
   localparam int FLASH32_KHZ = 20890;
   // region codes
   typedef enum logic [3:0] {
      REG_NONE = 4'h0,
      REG_FLASH = 4'h1,
      REG_SRAM = 4'h2,
      REG_FAST = 4'h4,
      REG_SLOW = 4'h8
   } region_t;
endpackage : memory_map_pkg

// ==== region_decode.sv ====
/*
 region_decode: pure address to region classifier for the memory map.
 assumes the boot alias bit is supplied by the system control register.
*/
`timescale 1ns/1ns
module region_decode (
   // address in
   input wire logic [31:0] addr_i,
   input wire logic alias_flash_i,
   // decoded result
   output memory_map_pkg::region_t region_o,
   output logic [31:0] local_addr_o,
   output logic [4:0] periph_o
);
   // true when a sits in [base, base+size)
   function automatic logic in_range(input logic [31:0] a, input logic [31:0] base,
                                     input logic [31:0] size);
      in_range = (a >= base) && ((a - base) < size);
   endfunction : in_range

   logic [15:0] ofs;
   assign ofs = addr_i[15:0];

   // region and peripheral select; unoccupied space selects nothing
   always_comb begin
      region_o = memory_map_pkg::REG_NONE;
      local_addr_o = 32'h0000_0000;
      periph_o = 5'h00;
      // home window first: the flash alias covers it and would hide sram at boot
      if (in_range(addr_i, memory_map_pkg::SRAM_BASE, memory_map_pkg::SRAM_BYTES)) begin
         region_o = memory_map_pkg::REG_SRAM;
         local_addr_o = addr_i - memory_map_pkg::SRAM_BASE;
      end else if (in_range(addr_i, memory_map_pkg::ALIAS_BASE, memory_map_pkg::SRAM_BYTES) &&
                   !alias_flash_i) begin
         region_o = memory_map_pkg::REG_SRAM;
         local_addr_o = addr_i;
      end else if (in_range(addr_i, memory_map_pkg::ALIAS_BASE,
                            memory_map_pkg::FLASH_BYTES) && alias_flash_i) begin
         region_o = memory_map_pkg::REG_FLASH;
         local_addr_o = addr_i;
      end else if (in_range(addr_i, memory_map_pkg::FLASH_BASE,
                            memory_map_pkg::FLASH_BYTES)) begin
         region_o = memory_map_pkg::REG_FLASH;
         local_addr_o = addr_i - memory_map_pkg::FLASH_BASE;
      end else if (addr_i[31:16] == memory_map_pkg::PRS_BASE[31:16]) begin
         local_addr_o = {16'h0000, ofs};
         if (ofs >= memory_map_pkg::IRQ_OFS && ofs < memory_map_pkg::FIQ_OFS + 16'h0040) begin
            region_o = memory_map_pkg::REG_FAST;
            periph_o = (ofs >= memory_map_pkg::FIQ_OFS) ? 5'h01 : 5'h00;
         end else if (ofs >= memory_map_pkg::SYS_OFS && ofs < memory_map_pkg::SYS_OFS + 16'h0040) begin
            region_o = memory_map_pkg::REG_FAST;
            periph_o = 5'h02;
         end else if (ofs >= memory_map_pkg::TMR_OFS &&
                      ofs < memory_map_pkg::TMR_OFS + 16'h00A0) begin
            region_o = memory_map_pkg::REG_SLOW;
            periph_o = 5'h03;
         end else if (ofs >= memory_map_pkg::PWR_OFS && ofs < memory_map_pkg::PWR_OFS + 16'h0020) begin
            region_o = memory_map_pkg::REG_SLOW;
            periph_o = 5'h04;
         end else if (ofs >= memory_map_pkg::PSM_OFS && ofs < memory_map_pkg::PSM_OFS + 16'h0004) begin
            region_o = memory_map_pkg::REG_SLOW;
            periph_o = 5'h05;
         end else if (ofs >= memory_map_pkg::REF_OFS && ofs < memory_map_pkg::REF_OFS + 16'h0004) begin
            region_o = memory_map_pkg::REG_SLOW;
            periph_o = 5'h06;
         end else if (ofs >= memory_map_pkg::ADC_OFS && ofs < memory_map_pkg::ADC_OFS + 16'h0024) begin
            region_o = memory_map_pkg::REG_SLOW;
            periph_o = 5'h07;
         end else if (ofs >= memory_map_pkg::DAC_OFS && ofs < memory_map_pkg::DAC_OFS + 16'h0060) begin
            region_o = memory_map_pkg::REG_SLOW;
            periph_o = 5'h08;
         end else if (ofs >= memory_map_pkg::GPIO_OFS && ofs < memory_map_pkg::GPIO_OFS + 16'h0060) begin
            region_o = memory_map_pkg::REG_FAST;
            periph_o = 5'h09;
         end else if (ofs >= memory_map_pkg::NVC_OFS && ofs < memory_map_pkg::NVC_OFS + 16'h0100) begin
            region_o = memory_map_pkg::REG_FAST;
            periph_o = 5'h0A;
         end else if (ofs >= 16'h0800 && ofs < 16'h0C00) begin
            region_o = memory_map_pkg::REG_SLOW;
            periph_o = 5'h0B;
         end
      end
   end
endmodule : region_decode

// ==== memory_map_decoder.sv ====
/*
 memory_map_decoder: routes core accesses to nonvolatile memory, sram, fast or
 slow register bus; holds boot alias control and reset cause registers.
 assumes the core holds a request stable until ready_o, one access at a time.
*/
`timescale 1ns/1ns
module memory_map_decoder #(
   parameter int SRAM_WORDS = memory_map_pkg::SRAM_WORDS,
   parameter int FLASH_BANK_HW = memory_map_pkg::FLASH_BANK_HW
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // core request
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [31:0] addr_i,
   input wire logic [1:0] size_i,          // 0 byte, 1 half, 2 word
   input wire logic [31:0] wdata_i,
   // core answer
   output logic ready_o,
   output logic [31:0] rdata_o,
   output logic err_o,
   // reset cause capture
   input wire logic [7:0] reset_cause_i,
   // target selects
   output logic flash_sel_o,
   output logic sram_sel_o,
   output logic fast_sel_o,
   output logic slow_sel_o,
   output logic [4:0] periph_o,
   output logic [31:0] local_addr_o,
   output logic [3:0] byte_en_o,
   output logic [31:0] wdata_o,
   // flash side
   output logic [15:0] flash_hw_addr_o,
   output logic flash_bank_o,
   output logic flash_boot_o,
   output logic [7:0] flash_page_o,
   input wire logic [15:0] flash_rdata_i,
   // fast and slow register buses
   input wire logic [31:0] fast_rdata_i,
   input wire logic [31:0] slow_rdata_i
);
   initial begin
      if (SRAM_WORDS != 2048 || FLASH_BANK_HW != 32768)
         $error("memory_map_decoder: geometry is fixed by the map");
   end

   // access phases, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_HW2 = 4'b0100,
      ST_DONE = 4'b1000
   } phase_t;

   typedef struct packed {
      phase_t phase;
      logic [7:0] boot_alias;            // boot_alias_control
      logic [7:0] reset_cause;           // reset_cause_status
      logic captured;                    // cause latched after release
      logic [31:0] rdata;
      logic [15:0] low_hw;               // first flash halfword
      logic done;
      logic err;
   } state_t;

   state_t cur, next_cur;
   logic [31:0] sram_mem [SRAM_WORDS];   // sram array kept locally
   memory_map_pkg::region_t region;
   logic [31:0] laddr;
   logic [4:0] periph;
   logic sys_hit, sram_wr;
   logic [3:0] be;
   logic [31:0] wlane;

   region_decode u_dec (
      .addr_i(addr_i),
      .alias_flash_i(cur.boot_alias[memory_map_pkg::BOOT_ALIAS_BIT]),
      .region_o(region),
      .local_addr_o(laddr),
      .periph_o(periph)
   );

   // byte enables, little-endian lanes
   function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
      case (sz)
         2'h0: lanes = 4'h1 << a;
         2'h1: lanes = a[1] ? 4'hC : 4'h3;
         default: lanes = 4'hF;
      endcase
   endfunction : lanes

   assign be = lanes(size_i, addr_i[1:0]);
   // replicate narrow write data onto every lane so the low byte lands at its own address
   assign wlane = (size_i == 2'h0) ? {4{wdata_i[7:0]}} :
                  (size_i == 2'h1) ? {2{wdata_i[15:0]}} : wdata_i;
   assign sys_hit = (region == memory_map_pkg::REG_FAST) && (periph == 5'h02);
   assign sram_wr = req_i && we_i && (cur.phase == ST_IDLE) &&
                    (region == memory_map_pkg::REG_SRAM);

   // one-hot selects while a request is pending
   always_comb begin
      flash_sel_o = req_i && !cur.done && (region == memory_map_pkg::REG_FLASH);
      sram_sel_o = req_i && !cur.done && (region == memory_map_pkg::REG_SRAM);
      fast_sel_o = req_i && !cur.done && (region == memory_map_pkg::REG_FAST) && !sys_hit;
      slow_sel_o = req_i && !cur.done && (region == memory_map_pkg::REG_SLOW);
   end
   assign periph_o = periph;
   assign local_addr_o = laddr;
   assign byte_en_o = be;
   assign wdata_o = wlane;
   // flash geometry: bank, halfword, page, boot page flag
   assign flash_bank_o = laddr[16];
   // halfword index keeps address bit 1; the second fetch phase takes the odd index
   assign flash_hw_addr_o = {1'b0, laddr[15:2], laddr[1] | (cur.phase == ST_HW2)};
   assign flash_page_o = laddr[16:9];
   assign flash_boot_o = laddr[16] && (laddr[15:1] >= 15'(FLASH_BANK_HW - memory_map_pkg::FLASH_BOOT_HW));
   assign ready_o = cur.done;
   assign rdata_o = cur.rdata;
   assign err_o = cur.err;

   // sram array write with byte lanes
   always_ff @(posedge clk_i) begin
      if (sram_wr) begin
         for (int i = 0; i < 4; i++) begin
            if (be[i])
               sram_mem[laddr[12:2]][i*8 +: 8] <= wlane[i*8 +: 8];
         end
      end
   end

   // access sequencing and system registers
   always_comb begin
      next_cur = cur;
      next_cur.done = 1'b0;
      next_cur.err = 1'b0;
      if (!cur.captured) begin
         next_cur.reset_cause = reset_cause_i | memory_map_pkg::RST_CAUSE_RST;
         next_cur.captured = 1'b1;
      end
      case (cur.phase)
         ST_IDLE: begin
            if (req_i) begin
               case (region)
                  memory_map_pkg::REG_SRAM: begin
                     next_cur.rdata = sram_mem[laddr[12:2]];
                     next_cur.done = 1'b1;
                     next_cur.phase = ST_DONE;
                  end
                  memory_map_pkg::REG_FLASH: begin
                     next_cur.low_hw = flash_rdata_i;
                     if (size_i == 2'h2) begin
                        next_cur.phase = ST_HW2;
                     end else begin
                        next_cur.rdata = {2{flash_rdata_i}};
                        next_cur.done = 1'b1;
                        next_cur.phase = ST_DONE;
                     end
                  end
                  memory_map_pkg::REG_FAST: begin
                     next_cur.done = 1'b1;
                     next_cur.phase = ST_DONE;
                     next_cur.rdata = fast_rdata_i;
                     if (sys_hit) begin
                        next_cur.rdata = 32'h0000_0000;
                        if (laddr[15:0] == memory_map_pkg::BOOT_ALIAS_OFS) begin
                           next_cur.rdata = {24'h000000, cur.boot_alias};
                           if (we_i && be[0])
                              next_cur.boot_alias = wlane[7:0];
                        end else if (laddr[15:0] == memory_map_pkg::RST_CAUSE_OFS) begin
                           next_cur.rdata = {24'h000000, cur.reset_cause};
                        end else if (laddr[15:0] == memory_map_pkg::RST_CLEAR_OFS && we_i &&
                                     cur.captured) begin
                           // capture wins over a clear landing on the same edge
                           next_cur.reset_cause = cur.reset_cause & ~wlane[7:0];
                        end
                     end
                  end
                  memory_map_pkg::REG_SLOW: begin
                     next_cur.phase = ST_WAIT;
                  end
                  default: begin
                     next_cur.rdata = 32'h0000_0000;
                     next_cur.err = 1'b1;
                     next_cur.done = 1'b1;
                     next_cur.phase = ST_DONE;
                  end
               endcase
            end
         end
         ST_WAIT: begin
            next_cur.rdata = slow_rdata_i;
            next_cur.done = 1'b1;
            next_cur.phase = ST_DONE;
         end
         ST_HW2: begin
            next_cur.rdata = {flash_rdata_i, cur.low_hw};
            next_cur.done = 1'b1;
            next_cur.phase = ST_DONE;
         end
         ST_DONE: begin
            next_cur.phase = ST_IDLE; // one idle cycle between accesses
         end
         default: next_cur.phase = ST_IDLE;
      endcase
   end

   // state register; alias bit set on every reset
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cur <= '{phase: ST_IDLE, boot_alias: memory_map_pkg::BOOT_ALIAS_RST,
                  reset_cause: 8'h00, captured: 1'b0, rdata: 32'h0000_0000,
                  low_hw: 16'h0000, done: 1'b0, err: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   // fast access answers one cycle after take
   a_fast_one: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (cur.phase == ST_IDLE && req_i && region == memory_map_pkg::REG_FAST) |=> ready_o)
      else $error("fast access not answered in one cycle");
   // slow access answers after two cycles
   sequence s_slow_take;
      cur.phase == ST_IDLE && req_i && region == memory_map_pkg::REG_SLOW;
   endsequence
   a_slow_two: assert property (@(posedge clk_i) disable iff (!resetn_i)
      s_slow_take |=> !ready_o ##1 ready_o)
      else $error("slow access not answered in two cycles");
   a_flash_two: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (cur.phase == ST_IDLE && req_i && size_i == 2'h2 && region == memory_map_pkg::REG_FLASH)
      |=> cur.phase == ST_HW2 ##1 ready_o)
      else $error("word flash fetch not two halfword accesses");
   a_sel_onehot: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $onehot0({flash_sel_o, sram_sel_o, fast_sel_o, slow_sel_o}))
      else $error("more than one target selected");
   a_unmapped_err: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (cur.phase == ST_IDLE && req_i && region == memory_map_pkg::REG_NONE) |=> (ready_o && err_o))
      else $error("unoccupied address not refused");
   a_alias_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (cur.boot_alias[0] && addr_i == 32'h0000_0000) |-> region == memory_map_pkg::REG_FLASH)
      else $error("alias bit set but zero not flash");
   a_remap_sram: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (!cur.boot_alias[0] && addr_i == 32'h0000_0000) |-> region == memory_map_pkg::REG_SRAM)
      else $error("alias cleared but zero not sram");
   a_alias_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (cur.phase == ST_IDLE && req_i && we_i && sys_hit && be[0] &&
       laddr[15:0] == memory_map_pkg::BOOT_ALIAS_OFS) |=> cur.boot_alias == $past(wlane[7:0]))
      else $error("alias register write lost");
   a_gpio_fast: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (addr_i >= 32'hFFFF_0D00 && addr_i < 32'hFFFF_0D60) |->
      region == memory_map_pkg::REG_FAST)
      else $error("gpio not on fast bus");
   a_dac_slow: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (addr_i == 32'hFFFF_05DC) |-> (region == memory_map_pkg::REG_SLOW && periph == 5'h08))
      else $error("last output channel word not decoded");
endmodule : memory_map_decoder

// ==== memory_map_targets.sv ====
/*
 targets model: nonvolatile halfword array and register bus read data.
 assumes the decoder raises at most one select at a time.
*/
`timescale 1ns/1ns
module memory_map_targets (
   // clock
   input wire logic clk_i,
   // nonvolatile side
   input wire logic flash_sel_i,
   input wire logic flash_bank_i,
   input wire logic [15:0] flash_hw_addr_i,
   output logic [15:0] flash_rdata_o,
   // register buses
   input wire logic fast_sel_i,
   input wire logic slow_sel_i,
   output logic [31:0] fast_rdata_o,
   output logic [31:0] slow_rdata_o
);
   logic [15:0] churn = 16'h0000; // idle filler
   // released buses show a moving pattern so stale data never matches
   always_ff @(posedge clk_i) begin
      churn <= churn + 16'h1357;
   end
   // one 16-bit halfword per access, value tied to bank and index
   assign flash_rdata_o = flash_sel_i ? ({flash_bank_i, flash_hw_addr_i[14:0]} ^ 16'hA5C3)
      : churn;
   // fixed answers while selected
   assign fast_rdata_o = fast_sel_i ? 32'h1A2B3C4D : {churn, ~churn};
   assign slow_rdata_o = slow_sel_i ? 32'h5E6F7081 : {~churn, churn};
endmodule : memory_map_targets

// ==== memory_map_decoder_tb_top.sv ====
/*
 testbench: core-side access tasks and table of expected routes.
 assumes the targets model answers for nonvolatile and register buses.
*/
`timescale 1ns/1ns
module memory_map_decoder_tb_top;
   // core side
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic req_i = 1'b0;
   logic we_i = 1'b0;
   logic [31:0] addr_i = 32'h0;
   logic [1:0] size_i = 2'h0;
   logic [31:0] wdata_i = 32'h0;
   logic [7:0] reset_cause_i = 8'h04; // cause seen at release
   logic ready_o, err_o, flash_sel_o, sram_sel_o, fast_sel_o, slow_sel_o;
   logic flash_bank_o, flash_boot_o;
   logic [4:0] periph_o;
   logic [31:0] rdata_o, local_addr_o, wdata_o, fast_rdata_i, slow_rdata_i;
   logic [3:0] byte_en_o;
   logic [15:0] flash_hw_addr_o, flash_rdata_i;
   logic [7:0] flash_page_o;
   int fails = 0;
   int samples_checked = 0;
   // snapshot of one access
   int cyc;
   logic [31:0] rd, la, wd;
   logic er;
   logic [3:0] sel, be;
   logic [4:0] grp;
   logic [25:0] fl;
   logic [7:0] pg0;
   // peripheral table: offset, group, cycles, select
   logic [15:0] ofs [11] = '{16'h0000, 16'h0100, 16'h0320, 16'h0400, 16'h0440,
      16'h0480, 16'h0500, 16'h05D8, 16'h0D00, 16'h0E00, 16'h0800};
   int grp_x [11] = '{0, 1, 3, 4, 5, 6, 7, 8, 9, 10, 11};
   int cyc_x [11] = '{1, 1, 2, 2, 2, 2, 2, 2, 1, 1, 2};
   memory_map_decoder u_memory_map_decoder (.clk_i, .resetn_i, .req_i, .we_i, .addr_i,
      .size_i, .wdata_i, .ready_o, .rdata_o, .err_o, .reset_cause_i, .flash_sel_o,
      .sram_sel_o, .fast_sel_o, .slow_sel_o, .periph_o, .local_addr_o, .byte_en_o,
      .wdata_o, .flash_hw_addr_o, .flash_bank_o, .flash_boot_o, .flash_page_o,
      .flash_rdata_i, .fast_rdata_i, .slow_rdata_i);
   memory_map_targets u_memory_map_targets (.clk_i, .flash_sel_i(flash_sel_o),
      .flash_bank_i(flash_bank_o), .flash_hw_addr_i(flash_hw_addr_o),
      .flash_rdata_o(flash_rdata_i), .fast_sel_i(fast_sel_o), .slow_sel_i(slow_sel_o),
      .fast_rdata_o(fast_rdata_i), .slow_rdata_o(slow_rdata_i));
   // 50 ns core clock
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   // expected halfword from the array model
   function automatic logic [15:0] fv(input logic b, input logic [15:0] a);
      return {b, a[14:0]} ^ 16'hA5C3;
   endfunction : fv
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, seen);
         fails++;
      end
   endtask : chk
   task automatic complete_run();
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   // one request held until ready, then the dead cycle
   task automatic acc(input logic w, input logic [31:0] a, input logic [1:0] s,
      input logic [31:0] d);
      req_i = 1'b1;
      we_i = w;
      addr_i = a;
      size_i = s;
      wdata_i = d;
      #1;
      sel = {flash_sel_o, sram_sel_o, fast_sel_o, slow_sel_o};
      be = byte_en_o;
      grp = periph_o;
      la = local_addr_o;
      wd = wdata_o;
      fl = {flash_boot_o, flash_bank_o, flash_page_o, flash_hw_addr_o};
      for (cyc = 1; cyc < 9; cyc++) begin
         @(posedge clk_i);
         #1;
         if (ready_o === 1'b1) break;
      end
      // bounded wait ran out
      if (cyc == 9) begin
         fails++;
         complete_run();
      end
      rd = rdata_o;
      er = err_o;
      req_i = 1'b0;
      @(posedge clk_i);
      #1;
   endtask : acc
   // main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      #1;
      resetn_i = 1'b1;
      acc(1'b0, 32'hFFFF0220, 2'h2, 32'h0);
      reset_cause_i = 8'h00;
      chk("alias_reg", rd, 32'h1);
      chk("alias_cyc", 32'(cyc), 32'h1);
      acc(1'b0, 32'hFFFF0230, 2'h2, 32'h0);
      chk("cause", rd, 32'h5);
      acc(1'b1, 32'hFFFF0234, 2'h0, 32'hFF);
      acc(1'b0, 32'hFFFF0230, 2'h2, 32'h0);
      chk("cause_clr", rd, 32'h0);
      // word fetch at zero reaches the nonvolatile array
      acc(1'b0, 32'h0, 2'h2, 32'h0);
      chk("zero_sel", 32'(sel), 32'h8);
      chk("fetch_data", rd, {fv(1'b0, 16'h1), fv(1'b0, 16'h0)});
      chk("fetch_cyc", 32'(cyc), 32'h2);
      // sram home stays reachable while the alias is set
      acc(1'b0, 32'h00010000, 2'h2, 32'h0);
      chk("sram_home", 32'(sel), 32'h4);
      // boot page boundary in the upper bank
      acc(1'b0, 32'h0009F7FE, 2'h1, 32'h0);
      pg0 = fl[23:16];
      chk("half_rd", rd, {2{fv(1'b1, 16'h7BFF)}});
      chk("flash_ofs", la, 32'h0001F7FE);
      chk("user_top", 32'(fl[25:24]), 32'h1);
      acc(1'b0, 32'h0009F800, 2'h1, 32'h0);
      chk("boot_pg", 32'({fl[25:24], fl[15:0]}), 32'h37C00);
      chk("page_step", 32'(fl[23:16]), 32'(pg0 + 8'h01));
      // remap sram to zero
      acc(1'b1, 32'hFFFF0220, 2'h0, 32'h0);
      acc(1'b0, 32'h0, 2'h2, 32'h0);
      chk("remap_sel", 32'(sel), 32'h4);
      chk("sram_cyc", 32'(cyc), 32'h1);
      // little-endian lanes
      acc(1'b1, 32'h00010000, 2'h2, 32'h11223344);
      acc(1'b1, 32'h00010003, 2'h0, 32'hAB);
      chk("byte_lane", 32'(be), 32'h8);
      chk("byte_data", wd, 32'hABABABAB);
      acc(1'b0, 32'h00010000, 2'h2, 32'h0);
      chk("byte_word", rd, 32'hAB223344);
      acc(1'b1, 32'h00010002, 2'h1, 32'hABCD);
      chk("half_lane", 32'(be), 32'hC);
      acc(1'b0, 32'h00010000, 2'h2, 32'h0);
      chk("half_word", rd, 32'hABCD3344);
      // peripheral groups
      for (int i = 0; i < 11; i++) begin
         acc(1'b0, 32'hFFFF0000 | 32'(ofs[i]), 2'h2, 32'h0);
         chk("local", la, 32'(ofs[i]));
         chk("group", 32'(grp), 32'(grp_x[i]));
         chk("reg_cyc", 32'(cyc), 32'(cyc_x[i]));
         if (i > 1) begin
            chk("bus_sel", 32'(sel), (cyc_x[i] == 2) ? 32'h1 : 32'h2);
            chk("bus_data", rd, (cyc_x[i] == 2) ? 32'h5E6F7081 : 32'h1A2B3C4D);
         end
      end
      // a mid-run reset brings the flash alias back
      resetn_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      resetn_i = 1'b1;
      acc(1'b0, 32'hFFFF0220, 2'h2, 32'h0);
      chk("alias_again", rd, 32'h1);
      acc(1'b0, 32'hFFFF0230, 2'h2, 32'h0);
      chk("cause_again", rd, 32'h1);
      // unoccupied space
      acc(1'b0, 32'hFFFF0600, 2'h2, 32'h0);
      chk("hole_err", 32'({er, sel}), 32'h10);
      chk("hole_data", rd, 32'h0);
      acc(1'b0, 32'h00070000, 2'h2, 32'h0);
      chk("gap_err", 32'({er, sel}), 32'h10);
      complete_run();
   end
endmodule : memory_map_decoder_tb_top
